// *** design/rsm_regs.v ***
// live converter/monitor status, first top mask and event flag registers over apb
// assumes raw status inputs synchronous to core_clk; top mask default comes from otp pins
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "rsm_consts.vh"

module rsm_regs (
	// clock and reset
	input  wire        core_clk,
	input  wire        srst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// raw converter state
	input  wire        conv_a_enabled,
	input  wire        conv_b_enabled,
	input  wire        conv_a_output_valid,
	input  wire        conv_b_output_valid,
	input  wire        conv_a_at_current_limit,
	input  wire        conv_b_at_current_limit,
	input  wire        stepup_enabled,
	input  wire        stepup_output_valid,
	input  wire        stepup_at_current_limit,
	// raw monitors
	input  wire        ext_monitor_a_valid,
	input  wire        ext_monitor_b_valid,
	input  wire        analog_supply_valid,
	input  wire        thermal_warning_live,
	input  wire        ext_clock_invalid,
	// event pulses
	input  wire        load_meas_done,
	input  wire        ext_clock_event,
	// otp defaults for the top mask
	input  wire [7:0]  otp_top_mask_first,
	// interrupt
	output wire        irq
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg  [7:0]              top_event_mask_first;
	reg                     otp_loaded;
	reg  [`RSM_EV_BITS-1:0] event_flags;
	reg  [`RSM_EV_BITS-1:0] event_mask;
	reg  [2:0]              pg_prev;
	reg                     therm_prev;

	wire       wr_en   = psel & penable & pwrite & pstrb[0];
	wire       rd_en   = psel & ~pwrite;
	wire [7:0] idx     = paddr[9:2];
	wire       aligned = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);

	function hit;
		input [7:0] want;
		begin
			hit = aligned & (idx == want);
		end
	endfunction

	wire mapped = hit(`RSM_IDX_STEPDOWN_STAT) | hit(`RSM_IDX_BOOST_STAT)
		| hit(`RSM_IDX_MONITOR_STAT) | hit(`RSM_IDX_TOP_MASK1)
		| hit(`RSM_IDX_TOP_LIVE) | hit(`RSM_IDX_EVT_FLAGS) | hit(`RSM_IDX_EVT_MASK);

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ----------------------------------------
	// live status words
	// ----------------------------------------
	reg [7:0] sd_word;
	reg [7:0] bo_word;
	reg [7:0] mon_word;
	reg [7:0] top_word;

	always @* begin
		sd_word = 8'h00;
		sd_word[`RSM_SD_B_EN]   = conv_b_enabled;
		sd_word[`RSM_SD_A_EN]   = conv_a_enabled;
		sd_word[`RSM_SD_B_PG]   = conv_b_output_valid;
		sd_word[`RSM_SD_A_PG]   = conv_a_output_valid;
		sd_word[`RSM_SD_B_ILIM] = conv_b_at_current_limit;
		sd_word[`RSM_SD_A_ILIM] = conv_a_at_current_limit;
		bo_word = 8'h00;
		bo_word[`RSM_BO_EN]   = stepup_enabled;
		bo_word[`RSM_BO_PG]   = stepup_output_valid;
		bo_word[`RSM_BO_ILIM] = stepup_at_current_limit;
		mon_word = 8'h00;
		mon_word[`RSM_MON_B]   = ext_monitor_b_valid;
		mon_word[`RSM_MON_A]   = ext_monitor_a_valid;
		mon_word[`RSM_MON_ANA] = analog_supply_valid;
		top_word = 8'h00;
		top_word[`RSM_TOP_THERM] = thermal_warning_live;
		top_word[`RSM_TOP_CLK]   = ext_clock_invalid;
	end

	// ----------------------------------------
	// event detection
	// ----------------------------------------
	wire [2:0] pg_now = {stepup_output_valid, conv_b_output_valid, conv_a_output_valid};
	wire [2:0] pg_evt = pg_now ^ pg_prev;
	reg  [`RSM_EV_BITS-1:0] ev_set;

	always @* begin
		ev_set = {`RSM_EV_BITS{1'b0}};
		ev_set[`RSM_EV_MEAS]  = load_meas_done & ~top_event_mask_first[`RSM_MK_MEAS];
		ev_set[`RSM_EV_CLK]   = ext_clock_event & ~top_event_mask_first[`RSM_MK_CLK];
		ev_set[`RSM_EV_THERM] = thermal_warning_live & ~therm_prev
			& ~top_event_mask_first[`RSM_MK_THERM];
		ev_set[`RSM_EV_A_PG]  = pg_evt[0];
		ev_set[`RSM_EV_B_PG]  = pg_evt[1];
		ev_set[`RSM_EV_BO_PG] = pg_evt[2];
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	wire [`RSM_EV_BITS-1:0] clr_bits = (wr_en & hit(`RSM_IDX_EVT_FLAGS))
		? pwdata[`RSM_EV_BITS-1:0] : {`RSM_EV_BITS{1'b0}};

	always @(posedge core_clk) begin
		if (srst) begin
			top_event_mask_first <= 8'h00;
			otp_loaded           <= 1'b0;
			event_flags          <= {`RSM_EV_BITS{1'b0}};
			event_mask           <= `RSM_EV_MASK_RST;
			pg_prev              <= 3'h0;
			therm_prev           <= 1'b0;
		end else begin
			pg_prev    <= pg_now;
			therm_prev <= thermal_warning_live;
			// otp default taken on the first cycle after reset release
			if (!otp_loaded) begin
				otp_loaded           <= 1'b1;
				top_event_mask_first <= otp_top_mask_first & `RSM_MK1_WMASK;
			end else if (wr_en && hit(`RSM_IDX_TOP_MASK1)) begin
				top_event_mask_first <= pwdata[7:0] & `RSM_MK1_WMASK;
			end
			// set wins over a simultaneous write-one clear
			event_flags <= (event_flags & ~clr_bits) | ev_set;
			if (wr_en && hit(`RSM_IDX_EVT_MASK))
				event_mask <= pwdata[`RSM_EV_BITS-1:0];
		end
	end

	assign irq = |(event_flags & ~event_mask);

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && !penable) begin
			prdata <= 32'h0000_0000;
			if (hit(`RSM_IDX_STEPDOWN_STAT))
				prdata[7:0] <= sd_word;
			else if (hit(`RSM_IDX_BOOST_STAT))
				prdata[7:0] <= bo_word;
			else if (hit(`RSM_IDX_MONITOR_STAT))
				prdata[7:0] <= mon_word;
			else if (hit(`RSM_IDX_TOP_MASK1))
				prdata[7:0] <= top_event_mask_first;
			else if (hit(`RSM_IDX_TOP_LIVE))
				prdata[7:0] <= top_word;
			else if (hit(`RSM_IDX_EVT_FLAGS))
				prdata[`RSM_EV_BITS-1:0] <= event_flags;
			else if (hit(`RSM_IDX_EVT_MASK))
				prdata[`RSM_EV_BITS-1:0] <= event_mask;
		end
	end

endmodule

// *** common/rsm_consts.vh ***
// register offsets, field positions and reset values of the live status and mask bank
// assumes a 32-bit apb slave, one aligned word per register
`ifndef RSM_CONSTS_VH
`define RSM_CONSTS_VH

// ----------------------------------------
// register indexes (byte address = 4 x index)
// ----------------------------------------
`define RSM_IDX_STEPDOWN_STAT  8'h26
`define RSM_IDX_BOOST_STAT     8'h27
`define RSM_IDX_MONITOR_STAT   8'h28
`define RSM_IDX_TOP_MASK1      8'h29
`define RSM_IDX_TOP_LIVE       8'h25
`define RSM_IDX_EVT_FLAGS      8'h30
`define RSM_IDX_EVT_MASK       8'h31

// ----------------------------------------
// step-down status fields
// ----------------------------------------
`define RSM_SD_B_EN      7
`define RSM_SD_B_PG      6
`define RSM_SD_B_ILIM    4
`define RSM_SD_A_EN      3
`define RSM_SD_A_PG      2
`define RSM_SD_A_ILIM    0

// ----------------------------------------
// boost and monitor status fields
// ----------------------------------------
`define RSM_BO_EN        3
`define RSM_BO_PG        2
`define RSM_BO_ILIM      0
`define RSM_MON_B        4
`define RSM_MON_A        2
`define RSM_MON_ANA      0

// ----------------------------------------
// top mask and top live fields
// ----------------------------------------
`define RSM_MK_MEAS      7
`define RSM_MK_CLK       3
`define RSM_MK_THERM     1
`define RSM_TOP_THERM    1
`define RSM_TOP_CLK      3
`define RSM_MK1_WMASK    8'h8a

// ----------------------------------------
// event flag / mask fields
// ----------------------------------------
`define RSM_EV_MEAS      0
`define RSM_EV_CLK       1
`define RSM_EV_THERM     2
`define RSM_EV_A_PG      3
`define RSM_EV_B_PG      4
`define RSM_EV_BO_PG     5
`define RSM_EV_BITS      6
`define RSM_EV_MASK_RST  6'h38

`endif

// *** dv/rsm_checker.sv ***
// assertions on the live status and mask bank ports
// assumes binding to rsm_regs with raw inputs synchronous to core_clk
`timescale 1ns/100ps
module rsm_chk (
	// clock and reset
	input wire        core_clk,
	input wire        srst,
	// apb
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire        pslverr,
	input wire [31:0] prdata,
	input wire        irq,
	// raw levels
	input wire        conv_a_enabled,
	input wire        conv_b_enabled,
	input wire        conv_a_output_valid,
	input wire        conv_b_output_valid,
	input wire        conv_a_at_current_limit,
	input wire        conv_b_at_current_limit,
	input wire        stepup_enabled,
	input wire        stepup_output_valid,
	input wire        stepup_at_current_limit,
	input wire        ext_monitor_a_valid,
	input wire        ext_monitor_b_valid,
	input wire        analog_supply_valid,
	input wire        thermal_warning_live
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence rd_at(logic [11:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	a_stepdown_live: assert property (rd_at(12'h098) |=> prdata[7:0] == {
		$past(conv_b_enabled), $past(conv_b_output_valid), 1'b0, $past(conv_b_at_current_limit),
		$past(conv_a_enabled), $past(conv_a_output_valid), 1'b0, $past(conv_a_at_current_limit)})
		else $error("stepdown status read mismatch");
	a_boost_live: assert property (rd_at(12'h09c) |=> prdata == {28'h0,
		$past(stepup_enabled), $past(stepup_output_valid), 1'b0, $past(stepup_at_current_limit)})
		else $error("boost status read mismatch");
	a_monitor_live: assert property (rd_at(12'h0a0) |=> prdata == {27'h0,
		$past(ext_monitor_b_valid), 1'b0, $past(ext_monitor_a_valid), 1'b0,
		$past(analog_supply_valid)}) else $error("monitor status read mismatch");
	a_thermal_live: assert property (rd_at(12'h094) |=>
		prdata[1] == $past(thermal_warning_live)) else $error("thermal live bit mismatch");
	a_mask_reserved: assert property (rd_at(12'h0a4) |=>
		(prdata & 32'hffffff75) == 32'h0) else $error("mask reserved bits not zero");
	a_unmapped_err: assert property (psel && penable && paddr == 12'h0a8 |-> pslverr)
		else $error("no error on unmapped access");
	a_mapped_ok: assert property (psel && penable && paddr == 12'h098 |-> !pslverr)
		else $error("error on mapped access");
	a_irq_after_reset: assert property ($fell(srst) |-> !irq && prdata == 32'h0)
		else $error("irq or read data not cleared by reset");
	a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed without a read");
endmodule
bind rsm_regs rsm_chk u_chk (.*);

// *** dv/rsm_regs_tb_top.sv ***
// self-checking bench for rsm_regs over apb
// drives all inputs but the clock, pstrb and otp_top_mask_first (tied to constants) by non-blocking assignment after the rising edge
`timescale 1ns/100ps
module rsm_regs_tb_top;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        meas = 1'b0;
	logic        clkev = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [13:0] raw = 14'h0;
	logic [7:0]  otp = 8'hff;
	logic [13:0] pats [4] = '{14'h3fff, 14'h0000, 14'h1555, 14'h2aaa};
	logic [7:0]  msk [3] = '{8'h80, 8'h08, 8'h02};
	logic        pready, pslverr, irq, se;
	logic [31:0] prdata, g;
	int          err_count = 0, compares = 0, i;
	rsm_regs uut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .conv_a_enabled(raw[2]), .conv_b_enabled(raw[5]),
		.conv_a_output_valid(raw[1]), .conv_b_output_valid(raw[4]),
		.conv_a_at_current_limit(raw[0]), .conv_b_at_current_limit(raw[3]),
		.stepup_enabled(raw[8]), .stepup_output_valid(raw[7]), .stepup_at_current_limit(raw[6]),
		.ext_monitor_a_valid(raw[10]), .ext_monitor_b_valid(raw[11]),
		.analog_supply_valid(raw[9]), .thermal_warning_live(raw[12]),
		.ext_clock_invalid(raw[13]), .load_meas_done(meas), .ext_clock_event(clkev),
		.otp_top_mask_first(otp), .irq(irq));
	initial forever #4 core_clk = ~core_clk;
	task report_and_stop;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		g = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(g, e);
	endtask
	task fire(input int k);
		@(posedge core_clk);
		meas <= (k == 0);
		clkev <= (k == 1);
		raw[12] <= (k == 2);
		@(posedge core_clk);
		meas <= 1'b0;
		clkev <= 1'b0;
		raw[12] <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
	initial begin
		#20000;
		err_count++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		repeat (2) @(posedge core_clk);
		rd(12'h0a4, 32'h8a);
		rd(12'h0c4, 32'h38);
		xfer(1'b1, 12'h0a4, 32'hff);
		rd(12'h0a4, 32'h8a);
		$display("test reset and mask done");
		for (i = 0; i < 4; i++) begin
			raw <= pats[i];
			xfer(1'b1, 12'h098, 32'hff);
			rd(12'h098, {24'h0, raw[5:4], 1'b0, raw[3:1], 1'b0, raw[0]});
			rd(12'h09c, {28'h0, raw[8:7], 1'b0, raw[6]});
			rd(12'h0a0, {27'h0, raw[11], 1'b0, raw[10], 1'b0, raw[9]});
			rd(12'h094, {28'h0, raw[13], 1'b0, raw[12], 1'b0});
		end
		raw <= 14'h0;
		rd(12'h0c0, 32'h38);
		xfer(1'b1, 12'h0c0, 32'h38);
		rd(12'h0c0, 32'h0);
		$display("test live status done");
		for (i = 0; i < 6; i++) begin
			xfer(1'b1, 12'h0a4, i[0] ? {24'h0, msk[i/2]} : 32'h0);
			fire(i / 2);
			chk({31'h0, irq}, {31'h0, ~i[0]});
			rd(12'h0c0, i[0] ? 32'h0 : 32'h1 << (i / 2));
			xfer(1'b1, 12'h0c0, 32'h3f);
			// the clear lands at the access edge; look once irq has settled
			@(posedge core_clk);
			chk({31'h0, irq}, 32'h0);
		end
		xfer(1'b1, 12'h0c4, 32'h3f);
		fire(0);
		chk({31'h0, irq}, 32'h0);
		rd(12'h0c0, 32'h1);
		$display("test interrupts done");
		rd(12'h0a8, 32'h0);
		chk({31'h0, se}, 32'h1);
		$display("test unmapped done");
		report_and_stop;
	end
endmodule
